// ---- core/dspag_top.sv ----
/*
  DSP address generation: two index pointers and two offset registers form
  long, intermediate and physical operand addresses, apply post-updates, and
  decode the accumulator-unit store selector.
  Assumes requests come from the CPU pipeline on the same clock, that the
  pipeline honours the stall output, and that page pointers arrive as inputs.
*/
// The implementer's own choices: the address map and strobed register access.
// Summary of operation
// - Offset registers: bits 15..1 writable, bit0 zero
// - Offsets used only with index pointers
// - Stall after offset register initialization
// - Parallel move uses pre-adjusted intermediate address
// - Long address equals unmodified index pointer
// - Physical address from page pointer, override
// - Post-update written back as final step
// - Plain mode: pointer unchanged
// - Post-increment adds two
// - Increment with move: move uses minus two
// - Post-decrement subtracts two
// - Decrement with move: move uses plus two
// - Offset post-increment adds offset
// - Offset increment with move: minus offset
// - Offset post-decrement subtracts offset
// - Offset decrement with move: plus offset
// - Store instruction selects accumulator-unit register
// - Bits 31..27 encode six store selections
// - Index pointers: bits 15..1 writable, even
`timescale 1ns/1ps
`default_nettype none
module dspag_top (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [15:0]               reg_rdata,
  input  wire dspag_pkg::dspag_req_t req,
  input  wire logic [4*dspag_pkg::DSPAG_PAGE_BITS-1:0] page_ptrs,
  input  wire logic                 page_override,
  input  wire logic [dspag_pkg::DSPAG_PAGE_BITS-1:0] override_page,
  output dspag_pkg::dspag_res_t     res,
  output logic                      stall,
  input  wire logic                 store_valid,
  input  wire logic [31:0]          store_instr,
  output logic [5:0]                store_onehot,
  output logic                      store_undef
);
  logic [15:0] offset_reg [2];
  logic [15:0] index_reg [2];
  logic [1:0]  stall_reg;
  logic        reg_hit;
  logic [15:0] ptr;
  logic [15:0] step;
  logic [15:0] post_addr;
  logic [15:0] pre_addr;
  logic [9:0]  page;

  function automatic logic [15:0] even16(input logic [15:0] v);
    even16 = v & dspag_pkg::DSPAG_EVEN_MASK;
  endfunction

  // Selected pointer and step size
  assign ptr = index_reg[req.index_sel];
  always_comb begin
    unique case (req.mode)
      dspag_pkg::DSPAG_MODE_INC_OFS,
      dspag_pkg::DSPAG_MODE_DEC_OFS: step = offset_reg[req.offset_sel];
      dspag_pkg::DSPAG_MODE_INC2,
      dspag_pkg::DSPAG_MODE_DEC2:    step = dspag_pkg::DSPAG_STEP_WORD;
      default:                       step = dspag_pkg::DSPAG_RESET_WORD;
    endcase
  end

  // Post-update and opposite pre-adjust for the parallel move
  always_comb begin
    unique case (req.mode)
      dspag_pkg::DSPAG_MODE_INC2, dspag_pkg::DSPAG_MODE_INC_OFS: begin
        post_addr = even16(ptr + step);
        pre_addr  = even16(ptr - step);
      end
      dspag_pkg::DSPAG_MODE_DEC2, dspag_pkg::DSPAG_MODE_DEC_OFS: begin
        post_addr = even16(ptr - step);
        pre_addr  = even16(ptr + step);
      end
      default: begin
        post_addr = ptr;
        pre_addr  = ptr;
      end
    endcase
  end

  assign page = page_override ? override_page
                : page_ptrs[ptr[15:14]*dspag_pkg::DSPAG_PAGE_BITS +: dspag_pkg::DSPAG_PAGE_BITS];

  // Address results registered for the memory stage
  always_ff @(posedge clk) begin
    if (rst) begin
      res <= '0;
    end else if (ce) begin
      res.valid     <= req.valid & ~stall;
      res.long_addr <= ptr;
      res.move_addr <= req.par_move ? pre_addr : ptr;
      if (req.arith && !page_override) begin
        // Arithmetic operands map into the dual-port RAM window
        res.phys_addr <= {12'h000, ptr[dspag_pkg::DSPAG_ARITH_BITS-1:0]};
      end else begin
        res.phys_addr <= {page, ptr[13:0]};
      end
    end
  end

  assign reg_hit = reg_addr <= dspag_pkg::DSPAG_OFF_INDEX1;

  // Offset registers: software write only
  always_ff @(posedge clk) begin
    if (rst) begin
      offset_reg[0] <= dspag_pkg::DSPAG_RESET_WORD;
      offset_reg[1] <= dspag_pkg::DSPAG_RESET_WORD;
    end else if (ce && reg_wr) begin
      if (reg_addr == dspag_pkg::DSPAG_OFF_OFFSET0) offset_reg[0] <= even16(reg_wdata);
      if (reg_addr == dspag_pkg::DSPAG_OFF_OFFSET1) offset_reg[1] <= even16(reg_wdata);
    end
  end

  // Index pointers: software write wins over a same-cycle post-update
  always_ff @(posedge clk) begin
    if (rst) begin
      index_reg[0] <= dspag_pkg::DSPAG_RESET_WORD;
      index_reg[1] <= dspag_pkg::DSPAG_RESET_WORD;
    end else if (ce) begin
      if (req.valid && !stall && req.word_op) begin
        index_reg[req.index_sel] <= post_addr;
      end
      if (reg_wr && reg_addr == dspag_pkg::DSPAG_OFF_INDEX0) index_reg[0] <= even16(reg_wdata);
      if (reg_wr && reg_addr == dspag_pkg::DSPAG_OFF_INDEX1) index_reg[1] <= even16(reg_wdata);
    end
  end

  // Hold the pipeline while a freshly written pointer or offset settles
  always_ff @(posedge clk) begin
    if (rst) begin
      stall_reg <= 2'h0;
    end else if (ce) begin
      if (reg_wr && reg_hit) begin
        stall_reg <= 2'(dspag_pkg::DSPAG_STALL_CYCLES);
      end else if (stall_reg != 2'h0) begin
        stall_reg <= stall_reg - 2'h1;
      end
    end
  end
  assign stall = stall_reg != 2'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        unique case (reg_addr)
          dspag_pkg::DSPAG_OFF_OFFSET0: reg_rdata <= offset_reg[0];
          dspag_pkg::DSPAG_OFF_OFFSET1: reg_rdata <= offset_reg[1];
          dspag_pkg::DSPAG_OFF_INDEX0:  reg_rdata <= index_reg[0];
          dspag_pkg::DSPAG_OFF_INDEX1:  reg_rdata <= index_reg[1];
          dspag_pkg::DSPAG_OFF_STATUS:  reg_rdata <= {15'h0000, stall};
          default:                      reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Store selector decode, one-hot in table order
  always_ff @(posedge clk) begin
    if (rst) begin
      store_onehot <= 6'h00;
      store_undef  <= 1'b0;
    end else if (ce) begin
      store_onehot <= 6'h00;
      store_undef  <= 1'b0;
      if (store_valid) begin
        unique case (store_instr[dspag_pkg::DSPAG_SEL_MSB:dspag_pkg::DSPAG_SEL_LSB])
          dspag_pkg::DSPAG_SEL_STATUS:  store_onehot <= 6'h01;
          dspag_pkg::DSPAG_SEL_ACC_HI:  store_onehot <= 6'h02;
          dspag_pkg::DSPAG_SEL_ACC_LIM: store_onehot <= 6'h04;
          dspag_pkg::DSPAG_SEL_ACC_LO:  store_onehot <= 6'h08;
          dspag_pkg::DSPAG_SEL_CONTROL: store_onehot <= 6'h10;
          dspag_pkg::DSPAG_SEL_REPEAT:  store_onehot <= 6'h20;
          default:                      store_undef  <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/dspag_pkg.sv ----
/*
  Package for the DSP address generation block: register offsets, reset values,
  addressing-mode and store-selector encodings, request and result carriers.
  Assumes a single CPU clock domain and a simple strobe register port.
*/
package dspag_pkg;
  localparam logic [3:0] DSPAG_OFF_OFFSET0 = 4'h0;
  localparam logic [3:0] DSPAG_OFF_OFFSET1 = 4'h1;
  localparam logic [3:0] DSPAG_OFF_INDEX0  = 4'h2;
  localparam logic [3:0] DSPAG_OFF_INDEX1  = 4'h3;
  localparam logic [3:0] DSPAG_OFF_STATUS  = 4'h4;
  localparam logic [15:0] DSPAG_RESET_WORD = 16'h0000;
  localparam logic [15:0] DSPAG_STEP_WORD  = 16'h0002;
  localparam logic [15:0] DSPAG_EVEN_MASK  = 16'hFFFE;
  localparam int DSPAG_STALL_CYCLES = 1;
  localparam int DSPAG_SEL_MSB = 31;
  localparam int DSPAG_SEL_LSB = 27;
  localparam int DSPAG_PAGE_BITS = 10;
  localparam int DSPAG_ARITH_BITS = 12;

  typedef enum logic [2:0] {
    DSPAG_MODE_PLAIN    = 3'h0,
    DSPAG_MODE_INC2     = 3'h1,
    DSPAG_MODE_DEC2     = 3'h2,
    DSPAG_MODE_INC_OFS  = 3'h3,
    DSPAG_MODE_DEC_OFS  = 3'h4
  } dspag_mode_t;

  typedef enum logic [4:0] {
    DSPAG_SEL_STATUS  = 5'h00,
    DSPAG_SEL_ACC_HI  = 5'h01,
    DSPAG_SEL_ACC_LIM = 5'h02,
    DSPAG_SEL_ACC_LO  = 5'h04,
    DSPAG_SEL_CONTROL = 5'h05,
    DSPAG_SEL_REPEAT  = 5'h06
  } dspag_sel_t;

  typedef struct packed {
    logic        valid;
    logic        index_sel;
    logic        offset_sel;
    dspag_mode_t mode;
    logic        par_move;
    logic        arith;
    logic        word_op;
    logic [1:0]  page_sel;
  } dspag_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] long_addr;
    logic [15:0] move_addr;
    logic [23:0] phys_addr;
  } dspag_res_t;
endpackage

// ---- test/dspag_sva.sv ----
/* Assertions on the dspag_top ports.
   Bound from the bench; one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module dspag_sva (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire logic [3:0]            reg_addr,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [15:0]           reg_rdata,
  input wire dspag_pkg::dspag_req_t req,
  input wire logic                  page_override,
  input wire dspag_pkg::dspag_res_t res,
  input wire logic                  stall,
  input wire logic                  store_valid,
  input wire logic [31:0]           store_instr,
  input wire logic [5:0]            store_onehot,
  input wire logic                  store_undef
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic tk;
  assign tk = ce && req.valid && !stall;
  a_rd_even: assert property (ce && reg_rd && reg_addr < 4'h4 |=> !reg_rdata[0]) else $error("odd read");
  a_take_res: assert property (tk |=> res.valid) else $error("no result");
  a_stall_hold: assert property (ce && req.valid && stall |=> !res.valid) else $error("taken in stall");
  a_wr_stall: assert property (ce && reg_wr && reg_addr < 4'h4 ##1 ce && !reg_wr |-> stall ##1 !stall)
    else $error("stall length");
  a_inc2_move: assert property (tk && req.par_move && req.mode == dspag_pkg::DSPAG_MODE_INC2
    |=> res.move_addr == res.long_addr - 16'h0002) else $error("move addr inc");
  a_dec2_move: assert property (tk && req.par_move && req.mode == dspag_pkg::DSPAG_MODE_DEC2
    |=> res.move_addr == res.long_addr + 16'h0002) else $error("move addr dec");
  a_phys_arith: assert property (tk && req.arith && !page_override
    |=> res.phys_addr == {12'h000, res.long_addr[11:0]}) else $error("arith phys");
  a_store_sel: assert property (ce && store_valid && store_instr[31:27] == 5'h04
    |=> store_onehot == 6'h08 && !store_undef) else $error("store select");
  a_store_undef: assert property (ce && store_valid && store_instr[31:27] == 5'h03
    |=> store_undef && store_onehot == 6'h00) else $error("store undefined");
endmodule
`default_nettype wire

// ---- test/dspag_pipe_model.sv ----
/* Stand-in for the CPU pipeline issuing address requests.
   Assumes the bench pulses go for one cycle per request. */
`timescale 1ns/1ps
`default_nettype none
module dspag_pipe_model (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  go,
  input  wire dspag_pkg::dspag_req_t cmd,
  input  wire logic                  stall,
  output dspag_pkg::dspag_req_t      req
);
  // A refused request must stand until taken, else it is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      req <= '0;
    end else if (go) begin
      req <= cmd;
    end else if (!stall) begin
      req.valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- test/dspag_top_bench.sv ----
/* Bench for dspag_top: registers, addressing modes, store selector.
   Assumes the package, checker and pipeline model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dspag_top_bench;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic        page_override = 1'b0, stall, store_valid = 1'b0, store_undef;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [31:0] store_instr = 32'h00000000;
  logic [5:0]  store_onehot;
  logic [9:0]  override_page = 10'h155;
  logic [39:0] page_ptrs = 40'hF0E1D2C3B4;
  int          n_errors = 0, n_tests = 0, cycles = 0;
  dspag_pkg::dspag_req_t cmd = '0, req;
  dspag_pkg::dspag_res_t res;
  always #12.5 clk = ~clk;
  dspag_top DUT (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req, .page_ptrs,
    .page_override, .override_page, .res, .stall, .store_valid, .store_instr, .store_onehot, .store_undef);
  dspag_pipe_model u_pipe (.clk, .rst, .go, .cmd, .stall, .req);
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(24'(reg_rdata), 24'(e));
  endtask
  // A nonzero wd writes offset 1 in the same cycle, so the request meets the stall
  task automatic op(input logic [2:0] m, input logic is, os, ar, ov, input logic [15:0] wd, el, em);
    logic [9:0] pg;
    int i;
    @(posedge clk);
    cmd <= '{1'b1, is, os, dspag_pkg::dspag_mode_t'(m), 1'b1, ar, 1'b1, 2'h0};
    {go, page_override} <= {1'b1, ov};
    if (wd != 16'h0000) {reg_addr, reg_wdata, reg_wr} <= {4'h1, wd, 1'b1};
    @(posedge clk);
    {go, reg_wr} <= 2'b00;
    i = 0;
    do begin
      @(posedge clk);
      #1 i++;
    end while (res.valid !== 1'b1 && i < 8);
    pg = ov ? override_page : page_ptrs[10*el[15:14] +: 10];
    chk(24'(res.long_addr), 24'(el));
    if (m != 3'h0) chk(24'(res.move_addr), 24'(em));
    chk(res.phys_addr, (ar && !ov) ? {12'h000, el[11:0]} : {pg, el[13:0]});
  endtask
  task automatic st(input logic [4:0] c, input logic [5:0] e);
    @(posedge clk);
    {store_valid, store_instr} <= {1'b1, c, 27'h5A5A5A5};
    @(posedge clk);
    store_valid <= 1'b0;
    #1 chk(24'(store_onehot), 24'(e));
    chk(24'(store_undef), 24'(e == 6'h00));
  endtask
  task automatic conclude();
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("[ERR] %0t run did not finish", $time);
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) rd(4'(a), 16'h0000);
    wr(4'h0, 16'h0007);
    wr(4'h2, 16'h0011);
    wr(4'h9, 16'hFFFF);
    rd(4'h0, 16'h0006);
    rd(4'h2, 16'h0010);
    rd(4'h9, 16'h0000);
    rd(4'h4, 16'h0000);
    @(posedge clk) ce <= 1'b0;
    wr(4'h0, 16'h00FE);
    ce <= 1'b1;
    rd(4'h0, 16'h0006);
    $display("register test done");
    op(3'h0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0010, 16'h0000);
    op(3'h1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0010, 16'h000E);
    op(3'h2, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0012, 16'h0014);
    op(3'h3, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0010, 16'h000A);
    op(3'h4, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0016, 16'h001C);
    op(3'h3, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0021, 16'h0010, 16'hFFF0);
    op(3'h2, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0002);
    op(3'h0, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0000, 16'hFFFE, 16'h0000);
    rd(4'h2, 16'h0030);
    rd(4'h3, 16'hFFFE);
    rd(4'h1, 16'h0020);
    $display("addressing test done");
    st(5'h00, 6'h01);
    st(5'h01, 6'h02);
    st(5'h02, 6'h04);
    st(5'h04, 6'h08);
    st(5'h05, 6'h10);
    st(5'h06, 6'h20);
    st(5'h03, 6'h00);
    st(5'h1F, 6'h00);
    $display("store test done");
    conclude();
  end
endmodule
bind dspag_top dspag_sva u_sva (.clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .req, .page_override,
  .res, .stall, .store_valid, .store_instr, .store_onehot, .store_undef);
`default_nettype wire
